// ===== core/srcs_pkg.sv
package srcs_pkg;
// Overview of operation
// - bus clock is oscillator divided by four, via half-rate clock halved again
// - after power-on or low voltage, clocks stay off through 4096 cycles, pin low
// - stop exit runs counter and holds clocks until 4096 or 32 cycles pass
// - wait mode stops CPU clock, peripheral clock keeps running
// - every reset asserts internal reset, defaults registers, selects the vector
// - internal resets clear the stabilisation counter, the external pin does not
// - the cause register flags whichever source caused the reset
// - external pin low halts processing; pin has a pull-up outside this logic
// - pin flag needs 67 low cycles, or 4163 after power-on or low voltage
// - internal sources drive the pin low 32 cycles, reset 32 more
// - power-on enables half-rate clock, pin low 4096 cycles, release 64 later
// - power-on sets its flag and clears all other cause flags except a pin flag set in that same cycle
// - watchdog overflow resets the chip and sets the watchdog flag
// - write to top address clears watchdog and counter stages 12 to 5
// - stabilisation counter output clocks the watchdog counter
// - watchdog disabled only combinationally by test high voltage on pins
// - illegal instruction sets its flag and resets the chip, pin low
// - stop with stop enable option clear is an illegal opcode
// - only opcode fetch from unmapped address resets, data access does not
// - low voltage sets its flag, pin low 4096 cycles, release 64 later
// - counter has 12 stages plus a 13th; the carry out of the 12 stages feeds the watchdog
// - stabilisation counter advances on the falling clock edge
// - short recovery option one gives 32 cycles, zero gives 4096

  localparam int unsigned CNT_W  = 13;
  localparam int unsigned WDOG_W = 6;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  localparam logic [CNT_W-1:0] CNT_ZERO      = 13'h0000;
  localparam logic [CNT_W-1:0] CNT_STEP      = 13'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX       = 13'h1FFF;
  localparam logic [CNT_W-1:0] CNT_KEEP_MASK = 13'h100F;
  localparam logic [11:0]      CNT_LOW_ALL   = 12'hFFF;

  localparam logic [CNT_W-1:0] LONG_PIN_END  = 13'h1000;
  localparam logic [CNT_W-1:0] LONG_RST_END  = 13'h1040;
  localparam logic [CNT_W-1:0] SHORT_PIN_END = 13'h0020;
  localparam logic [CNT_W-1:0] SHORT_RST_END = 13'h0040;
  localparam logic [CNT_W-1:0] STOP_LONG     = 13'h1000;
  localparam logic [CNT_W-1:0] STOP_SHORT    = 13'h0020;
  localparam logic [CNT_W-1:0] PIN_MIN_OTHER = 13'h0043;
  localparam logic [CNT_W-1:0] PIN_MIN_POR   = 13'h1043;

  localparam logic [WDOG_W-1:0] WDOG_ZERO = 6'h00;
  localparam logic [WDOG_W-1:0] WDOG_STEP = 6'h01;
  localparam logic [WDOG_W-1:0] WDOG_MAX  = 6'h3F;

  localparam logic [ADDR_W-1:0] ADDR_CAUSE  = 16'h0040;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 16'h0041;
  localparam logic [ADDR_W-1:0] ADDR_WDOG   = 16'hFFFF;

  localparam int unsigned CAUSE_POR  = 7;
  localparam int unsigned CAUSE_PIN  = 6;
  localparam int unsigned CAUSE_WDOG = 5;
  localparam int unsigned CAUSE_ILLEGAL_OPCODE_FLAG = 4;
  localparam int unsigned CAUSE_ILLEGAL_ADDRESS_FLAG = 3;
  localparam int unsigned CAUSE_LVI  = 1;
  localparam logic [DATA_W-1:0] CAUSE_ZERO = 8'h00;

  localparam int unsigned CFG_STOP_EN   = 0;
  localparam int unsigned CFG_SHORT_REC = 1;
  localparam logic [DATA_W-1:0] CFG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CFG_MASK  = 8'h03;

  localparam logic [ADDR_W-1:0] VEC_USER    = 16'hFFFE;
  localparam logic [ADDR_W-1:0] VEC_MONITOR = 16'hFEFE;

  typedef enum logic [2:0] {
    ST_RUN      = 3'b000,
    ST_PIN_LOW  = 3'b001,
    ST_HOLD     = 3'b010,
    ST_EXT      = 3'b011,
    ST_STOP     = 3'b100,
    ST_STOP_REC = 3'b101,
    ST_WAIT     = 3'b110
  } srcs_state_type;

  function automatic logic srcs_reached(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] lim
  );
    return cnt >= lim;
  endfunction : srcs_reached

endpackage : srcs_pkg

// ===== core/srcs_cnt_if.sv
`timescale 1ns/1ns
`default_nettype none
interface srcs_cnt_if import srcs_pkg::*; ();
  logic             clear_all;
  logic             clear_upper;
  logic             run;
  logic [CNT_W-1:0] count;
  logic             wrap_tick;

  modport ctrl (output clear_all, output clear_upper, output run,
                input count, input wrap_tick);
  modport cnt  (input clear_all, input clear_upper, input run,
                output count, output wrap_tick);
endinterface : srcs_cnt_if
`default_nettype wire

// ===== core/srcs_stab_counter.sv
`timescale 1ns/1ns
`default_nettype none
module srcs_stab_counter import srcs_pkg::*; (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  srcs_cnt_if.cnt   cnt_bus
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             tick;
  } srcs_cnt_state_type;

  srcs_cnt_state_type st_ff;
  srcs_cnt_state_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (cnt_bus.clear_all) begin
      nxt_st.count = CNT_ZERO;
    end else begin
      if (cnt_bus.clear_upper) begin
        nxt_st.count = st_ff.count & CNT_KEEP_MASK;
      end
      if (cnt_bus.run) begin
        // carry out of the 12 stages toggles the 13th and clocks the watchdog
        if (st_ff.count[11:0] == CNT_LOW_ALL) begin
          nxt_st.tick = 1'b1;
        end
        nxt_st.count = nxt_st.count + CNT_STEP;
      end
    end
  end

  // falling edge keeps the counter half a cycle away from its readers
  always_ff @(negedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cnt_bus.count     = st_ff.count;
  assign cnt_bus.wrap_tick = st_ff.tick;

endmodule : srcs_stab_counter
`default_nettype wire

// ===== core/srcs_top.sv
`timescale 1ns/1ns
`default_nettype none
module srcs_top import srcs_pkg::*; (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_power_on_pulse,
  input  wire logic              i_low_voltage_detect,
  input  wire logic              i_rst_pin_in,
  output logic                   o_rst_pin_out,
  output logic                   o_rst_pin_oe,
  input  wire logic              i_rst_test_high_voltage,
  input  wire logic              i_irq_test_high_voltage,
  input  wire logic              i_monitor_mode,
  input  wire logic              i_break_state,
  input  wire logic              i_illegal_opcode,
  input  wire logic              i_opcode_fetch,
  input  wire logic              i_fetch_unmapped,
  input  wire logic              i_stop_exec,
  input  wire logic              i_wait_exec,
  input  wire logic              i_wake,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  output logic                   o_osc_half_clock,
  output logic                   o_bus_clock,
  output logic                   o_cpu_clk_en,
  output logic                   o_periph_clk_en,
  output logic                   o_internal_reset,
  output logic      [ADDR_W-1:0] o_reset_vector
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    srcs_state_type    state;
    logic [CNT_W-1:0]  pin_end;
    logic [CNT_W-1:0]  rst_end;
    logic              long_seq;
    logic [DATA_W-1:0] cause;
    logic [DATA_W-1:0] cfg;
    logic [WDOG_W-1:0] wdog;
    logic              pin_s1;
    logic              pin_s2;
    logic              oe_d1;
    logic              oe_d2;
    logic [CNT_W-1:0]  low_cnt;
    logic              clr_all;
    logic              clr_upper;
    logic              run;
    logic              osc_half;
    logic              bus_clk;
    logic              cpu_en;
    logic              per_en;
    logic              internal_reset;
    logic              pin_oe;
    logic [ADDR_W-1:0] vec;
    logic [DATA_W-1:0] rdata;
  } srcs_top_state_type;

  // reset behaves as a power-on sequence
  localparam srcs_top_state_type ST_RESET = '{
    state:    ST_PIN_LOW,
    pin_end:  LONG_PIN_END,
    rst_end:  LONG_RST_END,
    long_seq: 1'b1,
    cause:    DATA_W'(1) << CAUSE_POR,
    cfg:      CFG_RESET,
    pin_s1:   1'b1,
    pin_s2:   1'b1,
    oe_d1:    1'b1,
    oe_d2:    1'b1,
    run:      1'b1,
    internal_reset:     1'b1,
    pin_oe:   1'b1,
    vec:      VEC_USER,
    default:  '0
  };

  srcs_top_state_type st_ff;
  srcs_top_state_type nxt_st;

  srcs_cnt_if cnt_bus ();

  ////////////////////////////////////////////////////////////////////////////

  logic             pin_low;
  logic             ext_low;
  logic             wdog_off;
  logic             wdog_live;
  logic             wdog_ovf;
  logic             illegal_opcode_flag;
  logic             illegal_address_flag;
  logic             internal_src;
  logic             long_src;
  logic [CNT_W-1:0] pin_thr;
  logic [CNT_W-1:0] stop_delay;
  logic             wr_ok;

  assign pin_low = !st_ff.pin_s2;

  // our own drive shows through the synchroniser for two more cycles
  assign ext_low = pin_low
                && !st_ff.pin_oe
                && !st_ff.oe_d1
                && !st_ff.oe_d2;

  // no register bit can turn the watchdog off, only pin voltages
  assign wdog_off = (i_monitor_mode
                     && (i_rst_test_high_voltage || i_irq_test_high_voltage))
                 || (i_break_state && i_rst_test_high_voltage);

  assign wdog_live = !wdog_off
                  && ((st_ff.state == ST_RUN) || (st_ff.state == ST_WAIT));

  // tick is asynchronous to the bus clock; it is judged on the oscillator clock
  assign wdog_ovf = wdog_live
                 && cnt_bus.wrap_tick
                 && (st_ff.wdog == WDOG_MAX);

  assign illegal_opcode_flag = (st_ff.state == ST_RUN)
             && (i_illegal_opcode
                 || (i_stop_exec && !st_ff.cfg[CFG_STOP_EN]));

  // data accesses to unmapped space are harmless
  assign illegal_address_flag = (st_ff.state == ST_RUN)
             && i_opcode_fetch
             && i_fetch_unmapped;

  assign internal_src = wdog_ovf || illegal_opcode_flag || illegal_address_flag;

  assign long_src = i_power_on_pulse || i_low_voltage_detect;

  assign pin_thr = st_ff.long_seq ? PIN_MIN_POR : PIN_MIN_OTHER;

  assign stop_delay = st_ff.cfg[CFG_SHORT_REC] ? STOP_SHORT
                                               : STOP_LONG;

  // bus writes are ignored while the chip is held in reset
  assign wr_ok = i_wr && !st_ff.internal_reset;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    nxt_st = st_ff;
    nxt_st.clr_all   = 1'b0;
    nxt_st.clr_upper = 1'b0;
    nxt_st.rdata     = CAUSE_ZERO;

    nxt_st.pin_s1 = i_rst_pin_in;
    nxt_st.pin_s2 = st_ff.pin_s1;
    nxt_st.oe_d1  = st_ff.pin_oe;
    nxt_st.oe_d2  = st_ff.oe_d1;

    nxt_st.vec = i_monitor_mode ? VEC_MONITOR : VEC_USER;

    // half-rate clock runs from reset on, bus clock is half of it
    nxt_st.osc_half = !st_ff.osc_half;
    if (st_ff.osc_half) begin
      nxt_st.bus_clk = !st_ff.bus_clk;
    end

    // low time saturates so the flag sets only once per low period
    if (pin_low) begin
      if (st_ff.low_cnt != CNT_MAX) begin
        nxt_st.low_cnt = st_ff.low_cnt + CNT_STEP;
      end
    end else begin
      nxt_st.low_cnt = CNT_ZERO;
    end

    if (wdog_live && cnt_bus.wrap_tick) begin
      nxt_st.wdog = st_ff.wdog + WDOG_STEP;
    end

    if (i_rd) begin
      case (i_addr)
        ADDR_CAUSE: begin
          nxt_st.rdata = st_ff.cause;
        end
        ADDR_CONFIG: begin
          nxt_st.rdata = st_ff.cfg;
        end
        default: begin
          nxt_st.rdata = CAUSE_ZERO;
        end
      endcase
    end

    if (wr_ok) begin
      case (i_addr)
        ADDR_CONFIG: begin
          nxt_st.cfg = i_wdata & CFG_MASK;
        end
        ADDR_WDOG: begin
          nxt_st.wdog      = WDOG_ZERO;
          nxt_st.clr_upper = 1'b1;
        end
        default: begin
          nxt_st.cfg = st_ff.cfg;
        end
      endcase
    end

    if (long_src || internal_src) begin
      nxt_st.state   = ST_PIN_LOW;
      nxt_st.clr_all = 1'b1;
      nxt_st.run     = 1'b1;
      nxt_st.pin_oe  = 1'b1;
      nxt_st.internal_reset    = 1'b1;
      nxt_st.cpu_en  = 1'b0;
      nxt_st.per_en  = 1'b0;
      nxt_st.wdog    = WDOG_ZERO;
      nxt_st.cfg     = CFG_RESET;
      if (long_src) begin
        nxt_st.pin_end  = LONG_PIN_END;
        nxt_st.rst_end  = LONG_RST_END;
        nxt_st.long_seq = 1'b1;
      end else begin
        nxt_st.pin_end  = SHORT_PIN_END;
        nxt_st.rst_end  = SHORT_RST_END;
        nxt_st.long_seq = 1'b0;
      end
      if (i_power_on_pulse) begin
        nxt_st.cause = CAUSE_ZERO;
        nxt_st.cause[CAUSE_POR] = 1'b1;
      end else begin
        // several sources in one cycle all leave their mark
        if (i_low_voltage_detect) begin
          nxt_st.cause[CAUSE_LVI] = 1'b1;
        end
        if (wdog_ovf) begin
          nxt_st.cause[CAUSE_WDOG] = 1'b1;
        end
        if (illegal_opcode_flag) begin
          nxt_st.cause[CAUSE_ILLEGAL_OPCODE_FLAG] = 1'b1;
        end
        if (illegal_address_flag) begin
          nxt_st.cause[CAUSE_ILLEGAL_ADDRESS_FLAG] = 1'b1;
        end
      end
    end else if (ext_low && (st_ff.state != ST_EXT)) begin
      // counter is left running on purpose
      nxt_st.state  = ST_EXT;
      nxt_st.internal_reset   = 1'b1;
      nxt_st.cpu_en = 1'b0;
      nxt_st.per_en = 1'b0;
      nxt_st.wdog   = WDOG_ZERO;
      nxt_st.cfg    = CFG_RESET;
      nxt_st.run    = 1'b1;
    end else begin
      case (st_ff.state)
        ST_RUN: begin
          if (i_stop_exec && st_ff.cfg[CFG_STOP_EN]) begin
            nxt_st.state   = ST_STOP;
            nxt_st.clr_all = 1'b1;
            nxt_st.run     = 1'b0;
            nxt_st.cpu_en  = 1'b0;
            nxt_st.per_en  = 1'b0;
          end else if (i_wait_exec) begin
            nxt_st.state  = ST_WAIT;
            nxt_st.cpu_en = 1'b0;
            nxt_st.per_en = 1'b1;
          end
        end
        ST_PIN_LOW: begin
          if (srcs_reached(cnt_bus.count, st_ff.pin_end)) begin
            nxt_st.state  = ST_HOLD;
            nxt_st.pin_oe = 1'b0;
          end
        end
        ST_HOLD: begin
          if (srcs_reached(cnt_bus.count, st_ff.rst_end)) begin
            nxt_st.state  = ST_RUN;
            nxt_st.internal_reset   = 1'b0;
            nxt_st.cpu_en = 1'b1;
            nxt_st.per_en = 1'b1;
          end
        end
        ST_EXT: begin
          if (!pin_low) begin
            nxt_st.state    = ST_RUN;
            nxt_st.internal_reset     = 1'b0;
            nxt_st.cpu_en   = 1'b1;
            nxt_st.per_en   = 1'b1;
            nxt_st.long_seq = 1'b0;
          end
        end
        ST_STOP: begin
          if (i_wake) begin
            nxt_st.state = ST_STOP_REC;
            nxt_st.run   = 1'b1;
          end
        end
        ST_STOP_REC: begin
          if (srcs_reached(cnt_bus.count, stop_delay)) begin
            nxt_st.state  = ST_RUN;
            nxt_st.cpu_en = 1'b1;
            nxt_st.per_en = 1'b1;
          end
        end
        ST_WAIT: begin
          if (i_wake) begin
            nxt_st.state  = ST_RUN;
            nxt_st.cpu_en = 1'b1;
          end
        end
        default: begin
          nxt_st.state = ST_RUN;
        end
      endcase
    end

    // pin flag is set last so no other source can mask it
    if (pin_low && (st_ff.low_cnt == pin_thr)) begin
      nxt_st.cause[CAUSE_PIN] = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign cnt_bus.clear_all   = st_ff.clr_all;
  assign cnt_bus.clear_upper = st_ff.clr_upper;
  assign cnt_bus.run         = st_ff.run;

  srcs_stab_counter u_counter (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .cnt_bus (cnt_bus)
  );

  // open drain: only ever pulls low
  assign o_rst_pin_out    = 1'b0;
  assign o_rst_pin_oe     = st_ff.pin_oe;
  assign o_rdata          = st_ff.rdata;
  assign o_osc_half_clock = st_ff.osc_half;
  assign o_bus_clock      = st_ff.bus_clk;
  assign o_cpu_clk_en     = st_ff.cpu_en;
  assign o_periph_clk_en  = st_ff.per_en;
  assign o_internal_reset = st_ff.internal_reset;
  assign o_reset_vector   = st_ff.vec;

endmodule : srcs_top
`default_nettype wire

// ===== tb/srcs_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module srcs_pin_model (
  input  wire logic i_oe,
  input  wire logic i_out,
  input  wire logic i_ext_low,
  output logic      o_pin
);
  // pull-up wins when nobody pulls the wire low
  assign o_pin = i_oe ? i_out : !i_ext_low;
endmodule : srcs_pin_model
`default_nettype wire

// ===== tb/srcs_props.sv
`timescale 1ns/1ns
`default_nettype none
module srcs_props import srcs_pkg::*; (
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic              i_power_on_pulse,
  input wire logic              i_low_voltage_detect,
  input wire logic              i_rst_pin_in,
  input wire logic              i_illegal_opcode,
  input wire logic              i_wait_exec,
  input wire logic              i_monitor_mode,
  input wire logic              i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic              o_osc_half_clock,
  input wire logic              o_bus_clock,
  input wire logic              o_cpu_clk_en,
  input wire logic              o_periph_clk_en,
  input wire logic              o_rst_pin_oe,
  input wire logic              o_internal_reset,
  input wire logic [ADDR_W-1:0] o_reset_vector
);
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [15:0] oe_n_ff;
  logic [15:0] gap_ff;
  logic        armed_ff;
  ////////////////////////////////////////////////////////////////////////////////
  // long sources restart the drive, so restart the count too
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oe_n_ff  <= 16'h0000;
      gap_ff   <= 16'h0000;
      armed_ff <= 1'h0;
    end else begin
      oe_n_ff  <= (!o_rst_pin_oe || i_power_on_pulse || i_low_voltage_detect) ? 16'h0000
                  : oe_n_ff + 16'h0001;
      gap_ff   <= o_rst_pin_oe ? 16'h0000 : gap_ff + 16'h0001;
      armed_ff <= o_rst_pin_oe ? 1'h1 : (o_internal_reset ? armed_ff : 1'h0);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_half;
    $past(i_rst_n) |-> o_osc_half_clock != $past(o_osc_half_clock);
  endproperty
  a_half: assert property (p_half) else $error("half clock missed a toggle");
  property p_bus;
    $changed(o_bus_clock) |=> $stable(o_bus_clock) ##1 $changed(o_bus_clock);
  endproperty
  a_bus: assert property (p_bus) else $error("bus clock not a quarter rate");
  property p_oe_len;
    $fell(o_rst_pin_oe) |-> oe_n_ff inside {[31:35], [4095:4099]};
  endproperty
  a_oe_len: assert property (p_oe_len) else $error("pin drive length wrong");
  property p_gap;
    $fell(o_internal_reset) && armed_ff |-> gap_ff == 16'h0020 || gap_ff == 16'h0040;
  endproperty
  a_gap: assert property (p_gap) else $error("reset tail length wrong");
  property p_illegal_opcode_flag;
    i_illegal_opcode && o_cpu_clk_en && !o_internal_reset
      |=> o_rst_pin_oe && o_internal_reset && !o_cpu_clk_en;
  endproperty
  a_illegal_opcode_flag: assert property (p_illegal_opcode_flag) else $error("illegal op gave no reset");
  property p_wait;
    i_wait_exec && o_cpu_clk_en && !o_internal_reset && i_rst_pin_in && !i_power_on_pulse
      && !i_low_voltage_detect |=> !o_cpu_clk_en && o_periph_clk_en;
  endproperty
  a_wait: assert property (p_wait) else $error("wait entry clocks wrong");
  property p_idle;
    o_internal_reset |-> !o_cpu_clk_en && !o_periph_clk_en;
  endproperty
  a_idle: assert property (p_idle) else $error("clocks run in reset");
  property p_oe;
    o_rst_pin_oe |-> o_internal_reset;
  endproperty
  a_oe: assert property (p_oe) else $error("pin driven outside reset");
  property p_vec;
    $past(i_rst_n) |-> o_reset_vector == ($past(i_monitor_mode) ? VEC_MONITOR : VEC_USER);
  endproperty
  a_vec: assert property (p_vec) else $error("reset vector wrong");
  property p_rdata;
    $past(i_rst_n) && !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
  c_illegal_opcode_flag: cover property (i_illegal_opcode && o_cpu_clk_en);
  c_wake: cover property ($rose(o_cpu_clk_en));
  c_pin: cover property (!i_rst_pin_in && !o_rst_pin_oe);
endmodule : srcs_props
bind srcs_top srcs_props srcs_props_inst (.*);
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import srcs_pkg::*;
  logic              i_clk = 1'h0;
  logic              i_rst_n = 1'h0;
  logic [7:0]        ev = 8'h00;
  logic              i_power_on_pulse, i_low_voltage_detect, i_illegal_opcode, i_stop_exec;
  logic              i_wait_exec, i_wake, i_opcode_fetch, i_fetch_unmapped;
  logic              i_monitor_mode = 1'h0, i_break_state = 1'h0, ext_low = 1'h0;
  logic              i_rst_test_high_voltage = 1'h0, i_irq_test_high_voltage = 1'h0;
  logic              i_wr = 1'h0, i_rd = 1'h0;
  logic [ADDR_W-1:0] i_addr = 16'h0000;
  logic [DATA_W-1:0] i_wdata = 8'h00;
  logic              i_rst_pin_in, o_rst_pin_out, o_rst_pin_oe, o_osc_half_clock, o_bus_clock;
  logic              o_cpu_clk_en, o_periph_clk_en, o_internal_reset;
  logic [DATA_W-1:0] o_rdata, d;
  logic [ADDR_W-1:0] o_reset_vector;
  int                failures = 0, checks_done = 0, n;
  assign {i_fetch_unmapped, i_opcode_fetch, i_wake, i_wait_exec, i_stop_exec,
          i_illegal_opcode, i_low_voltage_detect, i_power_on_pulse} = ev;
  always #25 i_clk = ~i_clk;
  srcs_top srcs_top_inst (.*);
  srcs_pin_model srcs_pin_model_inst (.i_oe(o_rst_pin_oe), .i_out(o_rst_pin_out),
                                      .i_ext_low(ext_low), .o_pin(i_rst_pin_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge i_clk); i_addr <= a; i_wdata <= v; i_wr <= 1'h1;
    @(posedge i_clk); i_wr <= 1'h0;
  endtask : wr
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_clk); i_addr <= a; i_rd <= 1'h1;
    @(posedge i_clk); i_rd <= 1'h0;
    #1 chk(16'(o_rdata), 16'(e));
  endtask : rdc
  task automatic pulse(input logic [7:0] m);
    @(posedge i_clk); ev <= m;
    @(posedge i_clk); ev <= 8'h00;
    #1;
  endtask : pulse
  // bounded wait while the chosen output stays at lvl; k counts edges
  task automatic waitc(input int s, input logic lvl, output int k);
    logic [2:0] v;
    k = 0;
    v = {o_cpu_clk_en, o_internal_reset, o_rst_pin_oe};
    while (v[s] === lvl) begin
      @(posedge i_clk); #1;
      k++;
      v = {o_cpu_clk_en, o_internal_reset, o_rst_pin_oe};
      if (k > 9000) begin
        failures++;
        $display("Error at %0t: wait ran out", $time);
        results();
      end
    end
  endtask : waitc
  task automatic seq(input logic [7:0] m, input int lo, input int hi, input int gap,
                     input logic [7:0] cause);
    pulse(m);
    waitc(0, 1'h1, n);
    chk(16'(n >= lo && n <= hi), 16'h0001);
    waitc(1, 1'h1, n);
    chk(16'(n), 16'(gap));
    rdc(ADDR_CAUSE, cause);
  endtask : seq
  task automatic ext(input int len, input logic [7:0] cause);
    @(posedge i_clk); ext_low <= 1'h1;
    repeat (6) @(posedge i_clk);
    #1 chk(16'({o_rst_pin_oe, o_internal_reset, o_cpu_clk_en}), 16'h0002);
    repeat (len - 6) @(posedge i_clk);
    ext_low <= 1'h0;
    #1 waitc(1, 1'h1, n);
    rdc(ADDR_CAUSE, cause);
  endtask : ext
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge i_clk);
    failures++;
    $display("Error at %0t: run too long", $time);
    results();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    chk(16'({o_rst_pin_oe, o_internal_reset, o_cpu_clk_en}), 16'h0006);
    chk(16'(o_rst_pin_out), 16'h0000);
    i_rst_n <= 1'h1;
    waitc(0, 1'h1, n);
    chk(16'(n >= 4095 && n <= 4099), 16'h0001);
    waitc(1, 1'h1, n);
    chk(16'(n), 16'h0040);
    rdc(ADDR_CAUSE, 8'h80);
    wr(ADDR_CAUSE, 8'hFF);
    rdc(ADDR_CAUSE, 8'h80);
    rdc(ADDR_CONFIG, 8'h00);
    rdc(16'h0042, 8'h00);
    d = {6'h00, o_osc_half_clock, o_bus_clock};
    repeat (2) @(posedge i_clk);
    #1 chk(16'({o_osc_half_clock, o_bus_clock}), 16'({d[1], ~d[0]}));
    seq(8'h04, 31, 35, 32, 8'h90);
    pulse(8'h80);
    repeat (3) @(posedge i_clk);
    #1 chk(16'(o_internal_reset), 16'h0000);
    seq(8'hC0, 31, 35, 32, 8'h98);
    wr(ADDR_CONFIG, 8'h03);
    ext(60, 8'h98);
    rdc(ADDR_CONFIG, 8'h00);
    ext(100, 8'hD8);
    pulse(8'h10);
    chk(16'({o_cpu_clk_en, o_periph_clk_en}), 16'h0001);
    pulse(8'h20);
    chk(16'({o_cpu_clk_en, o_periph_clk_en}), 16'h0003);
    wr(ADDR_CONFIG, 8'h03);
    rdc(ADDR_CONFIG, 8'h03);
    pulse(8'h08);
    repeat (40) @(posedge i_clk);
    #1 chk(16'(o_cpu_clk_en), 16'h0000);
    pulse(8'h20);
    waitc(2, 1'h0, n);
    chk(16'(n >= 31 && n <= 35), 16'h0001);
    wr(ADDR_CONFIG, 8'h01);
    pulse(8'h08);
    pulse(8'h20);
    waitc(2, 1'h0, n);
    chk(16'(n >= 4095 && n <= 4099), 16'h0001);
    wr(ADDR_WDOG, 8'h5A);
    #1 chk(16'(o_internal_reset), 16'h0000);
    @(posedge i_clk); i_monitor_mode <= 1'h1;
    repeat (2) @(posedge i_clk);
    #1 chk(o_reset_vector, VEC_MONITOR);
    @(posedge i_clk); i_monitor_mode <= 1'h0;
    seq(8'h02, 4095, 4099, 64, 8'hDA);
    seq(8'h01, 4095, 4099, 64, 8'h80);
    seq(8'h08, 31, 35, 32, 8'h90);
    results();
  end
endmodule : testbench
`default_nettype wire
